//--- common/clm_pkg.sv
// Shared constants and types of the clock and low-power controller.
// Assumes one 100 MHz core clock; oscillators arrive as free-running pin levels.
package clm_pkg;
    // Oscillator source codes
    localparam logic [1:0] SRC_EXT_FAST = 2'h0; // ext_fast_crystal, 1 to 16 MHz
    localparam logic [1:0] SRC_INT_FAST = 2'h1; // int_fast_rc, 16 MHz
    localparam logic [1:0] SRC_EXT_SLOW = 2'h2; // ext_slow_crystal, 32.768 kHz
    localparam logic [1:0] SRC_INT_SLOW = 2'h3; // int_slow_rc, 38 kHz
    localparam int NUM_SRC = 4;

    // Prescaler: ratio is two to the power of the exponent
    localparam int PRESC_W = 3;
    localparam logic [PRESC_W-1:0] PRESC_RESET = 3'h3; // divide by 8
    localparam int CNT_W = 7;

    // Clock failure monitor timing
    localparam int CLK_PERIOD_NS = 10;
    localparam int FAIL_TIMEOUT_NS = 1000;
    localparam int FAIL_TIMEOUT_CYC = FAIL_TIMEOUT_NS / CLK_PERIOD_NS;
    localparam int FAIL_CNT_W = 8;

    localparam int NUM_PERIPH = 8;

    // Low-power modes, one-hot
    typedef enum logic [6:0] {
        LP_RUN         = 7'h01,
        LP_WAIT_IRQ    = 7'h02,
        LP_WAIT_EVENT  = 7'h04,
        LP_LOW_RUN     = 7'h08,
        LP_LOW_WAIT    = 7'h10,
        LP_HALT        = 7'h20,
        LP_ACTIVE_HALT = 7'h40
    } clm_lp_t;

    // Source switch sequencer
    typedef enum logic [2:0] {
        SW_IDLE = 3'h1,
        SW_PARK = 3'h2,
        SW_SWAP = 3'h4
    } clm_sw_t;
endpackage : clm_pkg

//--- rtl/clm_div.sv
// Power-of-two clock divider counting source edges.
// Assumes tick_i is a one-cycle pulse on every source edge, same clock.
`timescale 1ns/1ps
`default_nettype none
module clm_div
    import clm_pkg::*;
(
    input wire logic core_clk_i,
    input wire logic reset_i,
    input wire logic tick_i,
    input wire logic park_i,
    input wire logic restart_i,
    input wire logic [PRESC_W-1:0] exp_i,
    output logic div_o
);
    localparam logic [7:0] ONE8 = 8'h01;
    logic [CNT_W-1:0] cnt_q, cnt_d, lim;
    logic div_q, div_d;

    // Half-period length in source edges, less one
    assign lim = CNT_W'((ONE8 << exp_i) - ONE8);

    // Next count and output level
    always_comb begin
        cnt_d = cnt_q;
        div_d = div_q;
        if (restart_i) begin
            cnt_d = '0;
            div_d = 1'b0;
        end else if (park_i && !div_q) begin
            cnt_d = '0; // hold low while parked
        end else if (tick_i) begin
            if (cnt_q >= lim) begin
                cnt_d = '0;
                div_d = ~div_q;
            end else begin
                cnt_d = CNT_W'(cnt_q + 1'b1);
            end
        end
    end

    // Registers
    always_ff @(posedge core_clk_i) begin
        if (reset_i) begin
            cnt_q <= '0;
            div_q <= 1'b0;
        end else begin
            cnt_q <= cnt_d;
            div_q <= div_d;
        end
    end

    assign div_o = div_q;
endmodule : clm_div
`default_nettype wire

//--- rtl/clm_top.sv
// Clock source selection, prescaling, gating and low-power controls.
// Assumes oscillator pins are asynchronous levels well below 50 MHz.
`timescale 1ns/1ps
`default_nettype none
module clm_top
    import clm_pkg::*;
(
    input wire logic core_clk_i,
    input wire logic reset_i,
    input wire logic osc_ext_fast_i,
    input wire logic osc_int_fast_i,
    input wire logic osc_ext_slow_i,
    input wire logic osc_int_slow_i,
    input wire logic cfg_wr_i,
    input wire logic [1:0] cfg_src_i,
    input wire logic [PRESC_W-1:0] cfg_presc_i,
    input wire logic monitor_en_i,
    input wire logic fail_clear_i,
    input wire clm_lp_t lp_mode_i,
    input wire logic core_gate_en_i,
    input wire logic [NUM_PERIPH-1:0] periph_gate_en_i,
    input wire logic mem_gate_en_i,
    input wire logic [1:0] rtc_src_i,
    input wire logic clkout_en_i,
    input wire logic [1:0] clkout_src_i,
    input wire logic [PRESC_W-1:0] clkout_presc_i,
    input wire logic vref_auto_off_i,
    output logic core_root_clock_o,
    output logic cpu_clock_o,
    output logic [NUM_PERIPH-1:0] periph_clock_o,
    output logic mem_clock_o,
    output logic rtc_clock_o,
    output logic clock_out_pin_o,
    output logic main_regulator_mode_o,
    output logic lowpower_regulator_mode_o,
    output logic vref_on_o,
    output logic brownout_detector_en_o,
    output logic fail_flag_o,
    output logic [1:0] active_src_o,
    output logic switch_busy_o
);
    // Pick one bit by source code
    function automatic logic pick(input logic [NUM_SRC-1:0] v, input logic [1:0] s);
        pick = v[s];
    endfunction : pick

    logic [NUM_SRC-1:0] osc_raw, sync1_q, sync2_q, sync3_q, edge_w;
    logic [1:0] active_q, active_d, target_q, target_d;
    logic [PRESC_W-1:0] presc_q, presc_d;
    clm_sw_t sw_q, sw_d;
    logic [FAIL_CNT_W-1:0] mon_q, mon_d;
    logic flag_q, flag_d, fail_evt, root_div, out_div, park, restart;
    logic cpu_q, cpu_d, mem_q, mem_d, rtc_q, rtc_d;
    logic [NUM_PERIPH-1:0] per_q, per_d;
    logic mreg_q, mreg_d, vref_q, vref_d;

    assign osc_raw = {osc_int_slow_i, osc_ext_slow_i, osc_int_fast_i, osc_ext_fast_i};

    // Oscillator synchronisers plus edge stage
    always_ff @(posedge core_clk_i) begin
        if (reset_i) begin
            sync1_q <= '0;
            sync2_q <= '0;
            sync3_q <= '0;
        end else begin
            sync1_q <= osc_raw;
            sync2_q <= sync1_q;
            sync3_q <= sync2_q;
        end
    end
    assign edge_w = sync2_q ^ sync3_q;

    // Failure monitor: cycles since last fast crystal edge
    always_comb begin
        mon_d = mon_q;
        if (edge_w[SRC_EXT_FAST] || !monitor_en_i) begin
            mon_d = '0;
        end else if (mon_q < FAIL_CNT_W'(FAIL_TIMEOUT_CYC)) begin
            mon_d = FAIL_CNT_W'(mon_q + 1'b1);
        end
    end
    assign fail_evt = monitor_en_i && (mon_q == FAIL_CNT_W'(FAIL_TIMEOUT_CYC));

    // Configuration, sequencer and failure flag
    always_comb begin
        target_d = target_q;
        presc_d = presc_q;
        active_d = active_q;
        sw_d = sw_q;
        flag_d = flag_q;
        park = 1'b0;
        restart = 1'b0;
        if (cfg_wr_i) begin
            target_d = cfg_src_i;
            presc_d = cfg_presc_i;
        end
        if (fail_clear_i) begin
            flag_d = 1'b0;
        end
        unique case (sw_q)
            SW_IDLE: begin
                if (fail_evt && active_q == SRC_EXT_FAST) begin
                    // Dead source gives no edge to park on, cut over at once
                    active_d = SRC_INT_FAST;
                    target_d = SRC_INT_FAST;
                    flag_d = 1'b1; // set wins over clear
                    restart = 1'b1;
                end else if (target_q != active_q) begin
                    sw_d = SW_PARK;
                end
            end
            SW_PARK: begin
                park = 1'b1;
                if (!root_div) begin
                    sw_d = SW_SWAP;
                end
            end
            SW_SWAP: begin
                park = 1'b1;
                active_d = target_q;
                sw_d = SW_IDLE;
            end
        endcase
    end

    always_ff @(posedge core_clk_i) begin
        if (reset_i) begin
            target_q <= SRC_INT_FAST;
            active_q <= SRC_INT_FAST;
            presc_q <= PRESC_RESET;
            sw_q <= SW_IDLE;
            mon_q <= '0;
            flag_q <= 1'b0;
        end else begin
            target_q <= target_d;
            active_q <= active_d;
            presc_q <= presc_d;
            sw_q <= sw_d;
            mon_q <= mon_d;
            flag_q <= flag_d;
        end
    end

    // Root clock divider
    clm_div u_root_div (
        .core_clk_i(core_clk_i),
        .reset_i(reset_i),
        .tick_i(pick(edge_w, active_q)),
        .park_i(park),
        .restart_i(restart),
        .exp_i(presc_q),
        .div_o(root_div)
    );

    // Clock output pin divider
    clm_div u_out_div (
        .core_clk_i(core_clk_i),
        .reset_i(reset_i),
        .tick_i(pick(edge_w, clkout_src_i)),
        .park_i(1'b0),
        .restart_i(!clkout_en_i),
        .exp_i(clkout_presc_i),
        .div_o(out_div)
    );

    // Mode-dependent gating and regulator controls
    always_comb begin
        logic run_like, per_mode;
        run_like = (lp_mode_i == LP_RUN) || (lp_mode_i == LP_LOW_RUN);
        per_mode = (lp_mode_i != LP_HALT) && (lp_mode_i != LP_ACTIVE_HALT);
        cpu_d = root_div && core_gate_en_i && run_like;
        per_d = {NUM_PERIPH{root_div && per_mode}} & periph_gate_en_i;
        // Regulator choice first, the memory gate reads it
        mreg_d = (lp_mode_i == LP_RUN) || (lp_mode_i == LP_WAIT_IRQ)
            || (lp_mode_i == LP_WAIT_EVENT);
        // Memory runs only on the main regulator
        mem_d = root_div && mem_gate_en_i && mreg_d;
        rtc_d = pick(sync3_q, rtc_src_i) && (lp_mode_i != LP_HALT);
        vref_d = !((lp_mode_i == LP_HALT) && vref_auto_off_i);
    end

    always_ff @(posedge core_clk_i) begin
        if (reset_i) begin
            cpu_q <= 1'b0;
            per_q <= '0;
            mem_q <= 1'b0;
            rtc_q <= 1'b0;
            mreg_q <= 1'b1;
            vref_q <= 1'b1;
        end else begin
            cpu_q <= cpu_d;
            per_q <= per_d;
            mem_q <= mem_d;
            rtc_q <= rtc_d;
            mreg_q <= mreg_d;
            vref_q <= vref_d;
        end
    end

    assign core_root_clock_o = root_div;
    assign cpu_clock_o = cpu_q;
    assign periph_clock_o = per_q;
    assign mem_clock_o = mem_q;
    assign rtc_clock_o = rtc_q;
    assign clock_out_pin_o = out_div;
    assign main_regulator_mode_o = mreg_q;
    assign lowpower_regulator_mode_o = !mreg_q;
    assign vref_on_o = vref_q;
    assign brownout_detector_en_o = vref_q;
    assign fail_flag_o = flag_q;
    assign active_src_o = active_q;
    assign switch_busy_o = (sw_q != SW_IDLE);

    default clocking cb @(posedge core_clk_i); endclocking
    default disable iff (reset_i);

    // Checks
    reset_start_a: assert property (
        $fell(reset_i) |-> active_q == SRC_INT_FAST && presc_q == PRESC_RESET)
        else $error("bad reset source");
    cfg_take_a: assert property (
        cfg_wr_i && !fail_evt |=> target_q == $past(cfg_src_i) && presc_q == $past(cfg_presc_i))
        else $error("config not taken");
    // Outside a restart, root moves only when the prescaler count is used up
    presc_track_a: assert property (
        !restart && !(u_root_div.tick_i && u_root_div.cnt_q >= u_root_div.lim)
        |=> $stable(root_div))
        else $error("root toggled before count done");
    switch_low_a: assert property (
        sw_q == SW_SWAP |-> !root_div ##1 !root_div)
        else $error("switch not glitch free");
    fail_force_a: assert property (
        sw_q == SW_IDLE && fail_evt && active_q == SRC_EXT_FAST
        |=> active_q == SRC_INT_FAST && fail_flag_o)
        else $error("failure not handled");
    flag_hold_a: assert property (
        fail_flag_o && !fail_clear_i |=> fail_flag_o)
        else $error("flag lost");
    wait_core_a: assert property (
        (lp_mode_i == LP_WAIT_IRQ) [*2] |-> !cpu_clock_o && main_regulator_mode_o)
        else $error("wait mode gating");
    ahalt_stop_a: assert property (
        lp_mode_i == LP_ACTIVE_HALT
        |=> periph_clock_o == '0 && !cpu_clock_o && lowpower_regulator_mode_o)
        else $error("active-halt gating");
    halt_reg_a: assert property (
        lp_mode_i == LP_HALT
        |=> lowpower_regulator_mode_o && vref_on_o == !$past(vref_auto_off_i))
        else $error("halt regulator");
    rtc_src_a: assert property (
        lp_mode_i != LP_HALT |=> rtc_clock_o == $past(sync3_q[rtc_src_i]))
        else $error("calendar clock source");
endmodule : clm_top
`default_nettype wire

//--- test/clm_osc_model.sv
// Oscillator stand-ins: four free-running sources, fast crystal can fail.
// Assumes a 10 ns core clock; half periods are multiples of it.
`timescale 1ns/1ps
`default_nettype none
module clm_osc_model #(
    parameter int HALF_EF = 40,
    parameter int HALF_IF = 30,
    parameter int HALF_ES = 250,
    parameter int HALF_IS = 200
) (
    input wire logic fail_i,
    output logic osc_ext_fast_o,
    output logic osc_int_fast_o,
    output logic osc_ext_slow_o,
    output logic osc_int_slow_o
);
    // Sources start low and toggle on falling core clock edges, between rising ones
    initial begin
        osc_ext_fast_o = 1'b0;
        osc_int_fast_o = 1'b0;
        osc_ext_slow_o = 1'b0;
        osc_int_slow_o = 1'b0;
    end
    // A failed crystal stands still
    always #(HALF_EF) osc_ext_fast_o = fail_i ? osc_ext_fast_o : ~osc_ext_fast_o;
    always #(HALF_IF) osc_int_fast_o = ~osc_int_fast_o;
    always #(HALF_ES) osc_ext_slow_o = ~osc_ext_slow_o;
    always #(HALF_IS) osc_int_slow_o = ~osc_int_slow_o;
endmodule : clm_osc_model
`default_nettype wire

//--- test/test_clm_top.sv
// Testbench: sources, prescaler, gating, regulator and failure monitor.
// Assumes clm_osc_model drives the oscillator pins.
`timescale 1ns/1ps
`default_nettype none
module test_clm_top;
    import clm_pkg::*;
    logic core_clk_i = 1'b0;
    logic reset_i = 1'b1;
    logic osc_fail = 1'b0;
    logic cfg_wr = 1'b0;
    logic [1:0] cfg_src = 2'h1;
    logic [PRESC_W-1:0] cfg_presc = 3'h3;
    logic mon_en = 1'b0;
    logic fail_clr = 1'b0;
    clm_lp_t lp_mode = LP_RUN;
    logic core_gate = 1'b1;
    logic [NUM_PERIPH-1:0] periph_gate = 8'hFF;
    logic mem_gate = 1'b1;
    logic clkout_en = 1'b1;
    logic vref_auto = 1'b0;
    logic [1:0] rtc_src = 2'h3;
    logic [1:0] cko_src = 2'h2;
    logic [PRESC_W-1:0] cko_presc = 3'h0;
    logic root, root_d, cpu, mem, rtc, cko, mreg, lreg, vref, bod, flag, busy;
    logic [3:0] osc;
    logic [NUM_PERIPH-1:0] periph;
    logic [1:0] act;
    logic [11:0] seen;
    logic [11:0] exp;
    int n_mismatch = 0;
    int num_checks = 0;
    int rises = 0;
    int per_cnt = 0;
    int last_per = 0;
    int p, p1, n;
    localparam int OSC_PER [4] = '{80, 60, 500, 400};

    always #5 core_clk_i = ~core_clk_i;

    clm_osc_model OSC (.fail_i(osc_fail), .osc_ext_fast_o(osc[0]), .osc_int_fast_o(osc[1]),
        .osc_ext_slow_o(osc[2]), .osc_int_slow_o(osc[3]));

    clm_top DUT (.core_clk_i(core_clk_i), .reset_i(reset_i), .osc_ext_fast_i(osc[0]),
        .osc_int_fast_i(osc[1]), .osc_ext_slow_i(osc[2]), .osc_int_slow_i(osc[3]),
        .cfg_wr_i(cfg_wr), .cfg_src_i(cfg_src), .cfg_presc_i(cfg_presc), .monitor_en_i(mon_en),
        .fail_clear_i(fail_clr), .lp_mode_i(lp_mode), .core_gate_en_i(core_gate),
        .periph_gate_en_i(periph_gate), .mem_gate_en_i(mem_gate), .rtc_src_i(rtc_src),
        .clkout_en_i(clkout_en), .clkout_src_i(cko_src), .clkout_presc_i(cko_presc),
        .vref_auto_off_i(vref_auto), .core_root_clock_o(root), .cpu_clock_o(cpu),
        .periph_clock_o(periph), .mem_clock_o(mem), .rtc_clock_o(rtc), .clock_out_pin_o(cko),
        .main_regulator_mode_o(mreg), .lowpower_regulator_mode_o(lreg), .vref_on_o(vref),
        .brownout_detector_en_o(bod), .fail_flag_o(flag), .active_src_o(act),
        .switch_busy_o(busy));

    // Root period in core cycles, rise to rise
    always @(posedge core_clk_i) begin
        root_d <= root;
        if (root === 1'b1 && root_d === 1'b0) begin
            last_per <= per_cnt;
            per_cnt <= 1;
            rises <= rises + 1;
        end else begin
            per_cnt <= per_cnt + 1;
        end
    end

    task automatic check(input string what, input logic [31:0] sv, input logic [31:0] ev);
        num_checks++;
        if (sv !== ev) begin
            n_mismatch++;
            $display("Error %s expected %0h seen %0h", what, ev, sv);
        end
    endtask : check

    task automatic cfg(input logic [1:0] s, input logic [2:0] pr);
        int k = 0;
        @(negedge core_clk_i);
        cfg_wr = 1'b1;
        cfg_src = s;
        cfg_presc = pr;
        @(negedge core_clk_i);
        cfg_wr = 1'b0;
        @(negedge core_clk_i);
        while (busy !== 1'b0 && k < 3000) begin
            @(negedge core_clk_i);
            k++;
        end
        check("switch_busy", busy, 0);
    endtask : cfg

    task automatic measure(output int pv);
        int r0 = rises;
        int k = 0;
        while (rises < r0 + 3 && k < 8000) begin
            @(negedge core_clk_i);
            k++;
        end
        check("root_rises", rises >= r0 + 3, 1'b1);
        pv = last_per;
    endtask : measure

    // Cycles between two changes of the calendar clock or clock output
    task automatic half_per(input logic sel, output int hp);
        logic v0;
        int k;
        hp = 0;
        k = 0;
        v0 = sel ? cko : rtc;
        while ((sel ? cko : rtc) === v0 && k < 200) begin
            @(negedge core_clk_i);
            k++;
        end
        v0 = sel ? cko : rtc;
        while ((sel ? cko : rtc) === v0 && hp < 200) begin
            @(negedge core_clk_i);
            hp++;
        end
    endtask : half_per

    // Which gated clocks toggle over a window
    task automatic watch(output logic [11:0] tg);
        logic [11:0] pv;
        logic [11:0] nw;
        tg = '0;
        pv = {cpu, periph, mem, rtc, cko};
        repeat (100) begin
            @(negedge core_clk_i);
            nw = {cpu, periph, mem, rtc, cko};
            tg = tg | (nw ^ pv);
            pv = nw;
        end
    endtask : watch

    task automatic summarize;
        $display("checks %0d mismatches %0d", num_checks, n_mismatch);
        if (n_mismatch == 0 && num_checks > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask : summarize

    // Watchdog against a hang
    initial begin
        #400000;
        n_mismatch++;
        summarize();
    end

    initial begin
        repeat (4) @(negedge core_clk_i);
        reset_i = 1'b0;
        check("active_src", act, SRC_INT_FAST);
        check("regulator", {mreg, lreg, vref, bod, flag}, 5'h16);
        measure(p);
        cfg(SRC_INT_FAST, 3'h0);
        measure(p1);
        check("startup_div", p, 8 * p1);
        $display("test reset done");
        for (int s = 0; s < NUM_SRC; s++) begin
            cfg(s[1:0], 3'h0);
            check("active_src", act, s[1:0]);
            measure(p);
            check("src_period", p * OSC_PER[1], p1 * OSC_PER[s]);
        end
        $display("test sources done");
        for (int e = 1; e < 8; e += 3) begin
            cfg(SRC_INT_FAST, e[2:0]);
            measure(p);
            check("presc_period", p, p1 << e);
        end
        $display("test prescaler done");
        cfg(SRC_INT_FAST, 3'h0);
        for (int ps = 0; ps < 2; ps++) begin
            core_gate = (ps == 0);
            periph_gate = ps ? 8'hA5 : 8'hFF;
            mem_gate = (ps == 0);
            clkout_en = (ps == 0);
            vref_auto = (ps == 1);
            for (int i = 0; i < 7; i++) begin
                lp_mode = clm_lp_t'(7'h01 << i);
                repeat (5) @(negedge core_clk_i);
                watch(seen);
                exp = {(i == 0 || i == 3) && core_gate, (i < 5) ? periph_gate : 8'h00,
                    (i < 3) && mem_gate, i != 5, clkout_en};
                check("cpu_clk", seen[11], exp[11]);
                check("periph_clk", seen[10:3], exp[10:3]);
                check("mem_rtc_clk", seen[2:1], exp[2:1]);
                if (i == 0) check("clock_out", seen[0], exp[0]);
                check("reg_mode", {mreg, lreg}, (i < 3) ? 2'b10 : 2'b01);
                check("vref", {vref, bod}, (i == 5 && vref_auto) ? 2'b00 : 2'b11);
            end
        end
        lp_mode = LP_RUN;
        $display("test gating done");
        // Calendar and output pin follow their own source choice
        clkout_en = 1'b1;
        cko_presc = 3'h1;
        for (int s = 0; s < NUM_SRC; s++) begin
            rtc_src = s[1:0];
            cko_src = s[1:0];
            repeat (60) @(negedge core_clk_i);
            half_per(1'b0, p);
            check("rtc_half", p * 20, OSC_PER[s]);
            half_per(1'b1, p);
            check("clkout_half", p * 10, OSC_PER[s]);
        end
        $display("test outputs done");
        cfg(SRC_EXT_FAST, 3'h0);
        osc_fail = 1'b1;
        repeat (300) @(negedge core_clk_i);
        check("no_monitor", {act, flag}, {SRC_EXT_FAST, 1'b0});
        mon_en = 1'b1;
        n = 0;
        while (act !== SRC_INT_FAST && n < 300) begin
            @(negedge core_clk_i);
            n++;
        end
        check("failover", {act, flag}, {SRC_INT_FAST, 1'b1});
        measure(p);
        check("failover_period", p, p1);
        osc_fail = 1'b0;
        repeat (5) @(negedge core_clk_i);
        fail_clr = 1'b1;
        @(negedge core_clk_i);
        fail_clr = 1'b0;
        check("flag_clear", flag, 0);
        $display("test failure done");
        summarize();
    end
endmodule : test_clm_top
`default_nettype wire
